// file: core/tbs_pkg.sv
/*
 * Constants and types for one hit-sorting readout channel.
 * Assumes a single 100 MHz clock with beam clock and accept inputs synchronous to it.
 */
// How it works
// R01: Accept selects requested bucket, streams it out.
// R02: Hit words routed by low 6 crossing bits.
// R03: Bucket cleared when crossing count wraps onto it.
// R04: Data older than 64 beam clocks unreadable.
// R05: Read bucket is crossing minus adjustable delay.
// R06: Readout ends before crossing X+64 refills bucket.
// R07: Accepts during a read queue eight deep.
// R08: Queued reads start after current, in order.
// R09: Each bucket holds 512 words of 36 bits.
// R10: Packets are built from 16-bit words.
// R11: Header/trailer carry event count, crossing, parity.
// R12: Timing source supplies beam clock and accept.
// R13: Link halves joined into 32-bit hit words.
// R14: Accept into full queue dropped, overflow sticks.
package tbs_pkg;
	localparam int BUCKETS = 64;
	localparam int IDX_W = 6;
	localparam int DEPTH = 512;
	localparam int PTR_W = 9;
	localparam int CNT_W = 10;
	localparam int ENTRY_W = 36;
	localparam int HIT_W = 32;
	localparam int HALF_W = 16;
	localparam int BCO_W = 8;
	localparam int BCO_LSB = 24;
	localparam int MEM_WORDS = BUCKETS * DEPTH;
	localparam int MEM_AW = IDX_W + PTR_W;
	localparam int Q_DEPTH = 8;
	localparam int Q_PTR_W = 3;
	localparam int Q_CNT_W = 4;
	localparam int EXPIRE_BC = 64;
	localparam logic [CNT_W-1:0] DEPTH_CNT = 10'h200;
	localparam logic [Q_CNT_W-1:0] Q_FULL = 4'h8;
	localparam logic [3:0] ENTRY_PAD = 4'h0;
	localparam logic [7:0] HDR_PAD = 8'h00;
	localparam logic [15:0] EVT_RESET = 16'h0000;
	localparam logic [15:0] PAR_RESET = 16'h0000;
	localparam logic [BCO_W-1:0] BCO_RESET = 8'h00;
	// Beam clock rate and the clock rate give the cycles per beam clock.
	localparam int BEAM_CLK_KHZ = 9400;
	localparam int CLK_KHZ = 100000;
	localparam int BEAM_CYCLES = CLK_KHZ / BEAM_CLK_KHZ;
	typedef enum logic [2:0] {
		RS_IDLE,
		RS_HEAD_EVT,
		RS_HEAD_BCO,
		RS_FETCH,
		RS_HI,
		RS_LO,
		RS_TRAIL
	} tbs_rd_state_e;
endpackage

// file: core/tbs_sorter.sv
/*
 * Hit sorter: joins link halves into hit words, files them into 64 crossing
 * buckets, and for each queued accept streams one bucket out as a 16-bit packet.
 * Assumes link, beam tick and accept inputs are synchronous to clk_i and
 * that the packet sink always takes a word when pkt_valid_o is high.
 */
`timescale 1ns/1ps
module tbs_sorter (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic en_i,
	input wire logic [15:0] link_half_i,
	input wire logic link_valid_i,
	input wire logic link_align_i,
	input wire logic beam_tick_i,
	input wire logic bco_sync_i,
	input wire logic first_level_accept_i,
	input wire logic [7:0] read_delay_i,
	output logic [15:0] pkt_data_o,
	output logic pkt_valid_o,
	output logic pkt_first_o,
	output logic pkt_last_o,
	output logic queue_overflow_o,
	output logic busy_o
);
	// Link joining and crossing counter.
	logic [15:0] hi_q, hi_d;
	logic have_hi_q, have_hi_d;
	logic [31:0] hit_q, hit_d;
	logic hit_v_q, hit_v_d;
	logic [7:0] bco_q, bco_d;

	always_comb begin
		hi_d = hi_q;
		have_hi_d = have_hi_q;
		hit_d = hit_q;
		hit_v_d = 1'b0;
		bco_d = bco_q;
		if (link_valid_i && link_align_i) begin
			hi_d = link_half_i; // see R13
			have_hi_d = 1'b1;
		end else if (link_valid_i && have_hi_q) begin
			hit_d = {hi_q, link_half_i}; // see R13
			hit_v_d = 1'b1;
			have_hi_d = 1'b0;
		end
		// The start sequence zeroes the count so all readout stays aligned.
		if (bco_sync_i) begin
			bco_d = tbs_pkg::BCO_RESET;
		end else if (beam_tick_i) begin
			bco_d = bco_q + 8'h01; // see R12
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hi_q <= 16'h0000;
			have_hi_q <= 1'b0;
			hit_q <= 32'h0000_0000;
			hit_v_q <= 1'b0;
			bco_q <= tbs_pkg::BCO_RESET;
		end else if (en_i) begin
			hi_q <= hi_d;
			have_hi_q <= have_hi_d;
			hit_q <= hit_d;
			hit_v_q <= hit_v_d;
			bco_q <= bco_d;
		end
	end

	// Bucket bookkeeping: fill count and the crossing each bucket now holds.
	logic [63:0][9:0] cnt_q, cnt_d;
	logic [63:0][7:0] stamp_q, stamp_d;
	logic [63:0] clear_vec;
	logic [5:0] hit_idx;
	logic wr_ok;
	logic [14:0] wr_addr;

	assign hit_idx = hit_q[tbs_pkg::BCO_LSB +: tbs_pkg::IDX_W]; // see R02
	assign wr_ok = hit_v_q && (clear_vec[hit_idx] || cnt_q[hit_idx] < tbs_pkg::DEPTH_CNT);
	// A hit landing in the clearing cycle goes to slot zero of the fresh bucket.
	assign wr_addr = {hit_idx, clear_vec[hit_idx] ? 9'h000 : cnt_q[hit_idx][8:0]};

	genvar b;
	generate
		for (b = 0; b < tbs_pkg::BUCKETS; b++) begin : g_bucket
			logic wr_here;
			assign wr_here = wr_ok && hit_idx == 6'(b); // see R02
			assign clear_vec[b] = (beam_tick_i || bco_sync_i) && bco_d[5:0] == 6'(b); // see R03
			always_comb begin
				cnt_d[b] = cnt_q[b] + {9'h000, wr_here};
				stamp_d[b] = stamp_q[b];
				if (clear_vec[b]) begin
					cnt_d[b] = {9'h000, wr_here}; // see R03
					stamp_d[b] = bco_d;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_q <= '0;
			stamp_q <= '0;
		end else if (en_i) begin
			cnt_q <= cnt_d;
			stamp_q <= stamp_d;
		end
	end

	// Bucket storage, one 512-entry region per bucket.
	logic [35:0] mem_q [tbs_pkg::MEM_WORDS]; // see R09
	logic [35:0] rdata_q;
	logic [14:0] rd_addr;

	always_ff @(posedge clk_i) begin
		if (en_i) begin
			if (wr_ok) begin
				mem_q[wr_addr] <= {tbs_pkg::ENTRY_PAD, hit_q};
			end
			rdata_q <= mem_q[rd_addr];
		end
	end

	// Pending accept queue holding the requested crossing of each accept.
	logic [7:0] q_mem_q [tbs_pkg::Q_DEPTH];
	logic [7:0] q_mem_d [tbs_pkg::Q_DEPTH];
	logic [2:0] q_wr_q, q_wr_d, q_rd_q, q_rd_d;
	logic [3:0] q_cnt_q, q_cnt_d;
	logic ovf_q, ovf_d;
	logic pop, push;

	assign push = first_level_accept_i && q_cnt_q != tbs_pkg::Q_FULL; // see R07

	always_comb begin
		for (int i = 0; i < tbs_pkg::Q_DEPTH; i++) begin
			q_mem_d[i] = q_mem_q[i];
		end
		q_wr_d = q_wr_q;
		q_rd_d = q_rd_q;
		q_cnt_d = q_cnt_q;
		ovf_d = ovf_q;
		if (push) begin
			q_mem_d[q_wr_q] = bco_q - read_delay_i; // see R05
			q_wr_d = q_wr_q + 3'h1;
		end
		// Dropping the accept keeps earlier entries intact; the flag tells software.
		if (first_level_accept_i && !push) begin
			ovf_d = 1'b1; // see R14
		end
		if (pop) begin
			q_rd_d = q_rd_q + 3'h1; // see R08
		end
		q_cnt_d = q_cnt_q + {3'h0, push} - {3'h0, pop};
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < tbs_pkg::Q_DEPTH; i++) begin
				q_mem_q[i] <= 8'h00;
			end
			q_wr_q <= 3'h0;
			q_rd_q <= 3'h0;
			q_cnt_q <= 4'h0;
			ovf_q <= 1'b0;
		end else if (en_i) begin
			q_mem_q <= q_mem_d;
			q_wr_q <= q_wr_d;
			q_rd_q <= q_rd_d;
			q_cnt_q <= q_cnt_d;
			ovf_q <= ovf_d;
		end
	end

	// Read sequencer and packet builder.
	tbs_pkg::tbs_rd_state_e st_q, st_d;
	logic [5:0] rd_idx_q, rd_idx_d;
	logic [7:0] rd_bco_q, rd_bco_d;
	logic [9:0] rd_ptr_q, rd_ptr_d, rd_lim_q, rd_lim_d;
	logic [15:0] par_q, par_d, evt_q, evt_d;
	logic [15:0] data_d;
	logic valid_d, first_d, last_d;
	logic [7:0] head;
	logic head_live;

	assign head = q_mem_q[q_rd_q];
	// A bucket is readable only if it still holds the crossing asked for.
	assign head_live = stamp_q[head[5:0]] == head; // see R04
	assign pop = st_q == tbs_pkg::RS_IDLE && q_cnt_q != 4'h0; // see R08
	assign rd_addr = {rd_idx_q, rd_ptr_q[8:0]};

	always_comb begin
		st_d = st_q;
		rd_idx_d = rd_idx_q;
		rd_bco_d = rd_bco_q;
		rd_ptr_d = rd_ptr_q;
		rd_lim_d = rd_lim_q;
		par_d = par_q;
		evt_d = evt_q;
		data_d = pkt_data_o;
		valid_d = 1'b0;
		first_d = 1'b0;
		last_d = 1'b0;
		case (st_q)
			tbs_pkg::RS_IDLE: begin
				if (pop) begin
					rd_bco_d = head; // see R01
					rd_idx_d = head[5:0];
					rd_ptr_d = 10'h000;
					rd_lim_d = head_live ? cnt_q[head[5:0]] : 10'h000; // see R04
					par_d = tbs_pkg::PAR_RESET;
					evt_d = evt_q + 16'h0001;
					st_d = tbs_pkg::RS_HEAD_EVT;
				end
			end
			tbs_pkg::RS_HEAD_EVT: begin
				data_d = evt_q; // see R11
				valid_d = 1'b1;
				first_d = 1'b1;
				par_d = par_q ^ evt_q;
				st_d = tbs_pkg::RS_HEAD_BCO;
			end
			tbs_pkg::RS_HEAD_BCO: begin
				data_d = {tbs_pkg::HDR_PAD, rd_bco_q}; // see R11
				valid_d = 1'b1;
				par_d = par_q ^ {tbs_pkg::HDR_PAD, rd_bco_q};
				st_d = rd_lim_q != 10'h000 ? tbs_pkg::RS_FETCH : tbs_pkg::RS_TRAIL;
			end
			tbs_pkg::RS_FETCH: begin
				// A wrap onto the bucket, now or since the last entry, would mix crossings.
				st_d = (clear_vec[rd_idx_q] || stamp_q[rd_idx_q] != rd_bco_q) ?
					tbs_pkg::RS_TRAIL : tbs_pkg::RS_HI; // see R06
			end
			tbs_pkg::RS_HI: begin
				data_d = rdata_q[31:16]; // see R10
				valid_d = 1'b1;
				par_d = par_q ^ rdata_q[31:16];
				st_d = tbs_pkg::RS_LO;
			end
			tbs_pkg::RS_LO: begin
				data_d = rdata_q[15:0]; // see R10
				valid_d = 1'b1;
				par_d = par_q ^ rdata_q[15:0];
				rd_ptr_d = rd_ptr_q + 10'h001; // see R01
				st_d = rd_ptr_d < rd_lim_q ? tbs_pkg::RS_FETCH : tbs_pkg::RS_TRAIL;
			end
			tbs_pkg::RS_TRAIL: begin
				data_d = par_q; // see R11
				valid_d = 1'b1;
				last_d = 1'b1;
				st_d = tbs_pkg::RS_IDLE;
			end
			default: begin
				st_d = tbs_pkg::RS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q <= tbs_pkg::RS_IDLE;
			rd_idx_q <= 6'h00;
			rd_bco_q <= 8'h00;
			rd_ptr_q <= 10'h000;
			rd_lim_q <= 10'h000;
			par_q <= tbs_pkg::PAR_RESET;
			evt_q <= tbs_pkg::EVT_RESET;
			pkt_data_o <= 16'h0000;
			pkt_valid_o <= 1'b0;
			pkt_first_o <= 1'b0;
			pkt_last_o <= 1'b0;
			queue_overflow_o <= 1'b0;
			busy_o <= 1'b0;
		end else if (en_i) begin
			st_q <= st_d;
			rd_idx_q <= rd_idx_d;
			rd_bco_q <= rd_bco_d;
			rd_ptr_q <= rd_ptr_d;
			rd_lim_q <= rd_lim_d;
			par_q <= par_d;
			evt_q <= evt_d;
			pkt_data_o <= data_d;
			pkt_valid_o <= valid_d;
			pkt_first_o <= first_d;
			pkt_last_o <= last_d;
			queue_overflow_o <= ovf_d;
			busy_o <= st_d != tbs_pkg::RS_IDLE;
		end
	end

	// Checks; a frozen cycle abandons any attempt in flight.
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i || !en_i);

	sequence s_head;
		pkt_valid_o && pkt_first_o ##1 pkt_valid_o && !pkt_first_o;
	endsequence
	sequence s_empty_pkt;
		!pkt_valid_o ##1 pkt_first_o ##1 pkt_valid_o ##1 pkt_last_o;
	endsequence

	a_join_words: assert property ( // see R13
		link_valid_i && !link_align_i && have_hi_q |=> hit_v_q && hit_q[15:0] == $past(link_half_i)
	) else $error("joined hit word does not carry the low half");
	a_route_index: assert property ( // see R02
		wr_ok && !clear_vec[hit_idx] |=> cnt_q[$past(hit_idx)] == $past(cnt_q[hit_idx]) + 10'h001
	) else $error("hit word not counted in its bucket");
	a_wrap_clear: assert property ( // see R03
		beam_tick_i && !bco_sync_i |=> cnt_q[bco_q[5:0]] <= 10'h001 && stamp_q[bco_q[5:0]] == bco_q
	) else $error("bucket not cleared on wrap");
	a_expired_empty: assert property ( // see R04
		pop && !head_live |-> ##1 s_empty_pkt
	) else $error("expired bucket produced data");
	a_delay_addr: assert property ( // see R05
		push |=> q_mem_q[$past(q_wr_q)] == $past(bco_q) - $past(read_delay_i)
	) else $error("queued address not crossing minus delay");
	a_abort_wrap: assert property ( // see R06
		st_q == tbs_pkg::RS_FETCH && clear_vec[rd_idx_q] |=> st_q == tbs_pkg::RS_TRAIL
	) else $error("read continued across bucket wrap");
	a_queue_bound: assert property ( // see R07
		q_cnt_q <= tbs_pkg::Q_FULL
	) else $error("accept queue exceeded its depth");
	a_start_in_order: assert property ( // see R08
		pkt_first_o |-> $past(st_q == tbs_pkg::RS_IDLE, 2) ##0 s_head
	) else $error("packet started while a read was running");
	a_overflow_set: assert property ( // see R14
		first_level_accept_i && q_cnt_q == tbs_pkg::Q_FULL |=> queue_overflow_o && q_cnt_q <= tbs_pkg::Q_FULL
	) else $error("accept into full queue not flagged");
	a_overflow_sticky: assert property ( // see R14
		queue_overflow_o |=> queue_overflow_o
	) else $error("overflow flag cleared");
endmodule

// file: testbench/tbs_link_model.sv
/*
 * Link card model: sends one hit word as a high half with the comma flag, then a low half.
 * Assumes send_i is a one-cycle pulse, spaced two cycles apart, synchronous to clk_i.
 */
`timescale 1ns/1ps
module tbs_link_model (
	input wire logic clk_i,
	input wire logic send_i,
	input wire logic [31:0] word_i,
	output logic [15:0] link_half_o,
	output logic link_valid_o,
	output logic link_align_o
);
	logic [15:0] low_q;
	logic pend_q;
	logic take;
	logic [31:0] word;
	initial begin
		link_half_o = 16'h0000;
		link_valid_o = 1'b0;
		link_align_o = 1'b0;
		pend_q = 1'b0;
	end
	always @(posedge clk_i) begin
		take = send_i;
		word = word_i;
		#1;
		link_valid_o = 1'b0;
		link_align_o = 1'b0;
		// An idle line toggles so that a stale half is never mistaken for data.
		link_half_o = ~link_half_o;
		if (pend_q) begin
			link_half_o = low_q;
			link_valid_o = 1'b1;
			pend_q = 1'b0;
		end else if (take) begin
			link_half_o = word[31:16];
			link_align_o = 1'b1;
			link_valid_o = 1'b1;
			low_q = word[15:0];
			pend_q = 1'b1;
		end
	end
endmodule

// file: testbench/tb.sv
/*
 * Self-checking bench for the hit sorter: fills buckets, fires accepts, checks packets.
 * Assumes the sink always takes words and beam ticks come only from this bench.
 */
`timescale 1ns/1ps
module tb;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic beam_tick_i = 1'b0;
	logic bco_sync_i = 1'b0;
	logic first_level_accept_i = 1'b0;
	logic [7:0] read_delay_i = 8'h00;
	logic send = 1'b0;
	logic [31:0] word = 32'h00000000;
	logic [15:0] link_half;
	logic link_valid, link_align;
	logic [15:0] pkt_data_o;
	logic pkt_valid_o, pkt_first_o, pkt_last_o, queue_overflow_o, busy_o;
	int mismatches = 0;
	int tests_run = 0;
	int seed = 82;
	int nhits;
	logic [7:0] cnt;
	logic [15:0] evt;
	logic [31:0] hits [tbs_pkg::DEPTH+1];
	logic [15:0] pkt_q [$];
	logic [1:0] flg_q [$];

	tbs_link_model tbs_link_model_inst (.clk_i(clk_i), .send_i(send), .word_i(word),
		.link_half_o(link_half), .link_valid_o(link_valid), .link_align_o(link_align));
	tbs_sorter tbs_sorter_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .en_i(1'b1),
		.link_half_i(link_half), .link_valid_i(link_valid), .link_align_i(link_align),
		.beam_tick_i(beam_tick_i), .bco_sync_i(bco_sync_i),
		.first_level_accept_i(first_level_accept_i), .read_delay_i(read_delay_i),
		.pkt_data_o(pkt_data_o), .pkt_valid_o(pkt_valid_o), .pkt_first_o(pkt_first_o),
		.pkt_last_o(pkt_last_o), .queue_overflow_o(queue_overflow_o), .busy_o(busy_o));

	initial begin
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (pkt_valid_o === 1'b1) begin
			pkt_q.push_back(pkt_data_o);
			flg_q.push_back({pkt_first_o, pkt_last_o});
		end
	end

	task automatic step();
		@(posedge clk_i);
		#1;
	endtask
	task automatic check16(input string n, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tick();
		beam_tick_i = 1'b1;
		step();
		beam_tick_i = 1'b0;
		cnt = cnt + 8'h01;
		repeat (tbs_pkg::BEAM_CYCLES - 1) step();
	endtask
	task automatic put_hits(input int n);
		logic [31:0] r;
		for (int i = 0; i < n; i++) begin
			r = $random(seed);
			hits[i] = {cnt, r[23:0]};
			word = hits[i];
			send = 1'b1;
			step();
			send = 1'b0;
			step();
		end
		repeat (4) step();
	endtask
	task automatic accept(input logic [7:0] d);
		read_delay_i = d;
		first_level_accept_i = 1'b1;
		step();
		first_level_accept_i = 1'b0;
	endtask
	function automatic logic [15:0] pkt_word(input int i, input logic [15:0] e, input logic [7:0] b);
		if (i == 0) return e;
		if (i == 1) return {8'h00, b};
		return (i % 2 == 0) ? hits[(i-2)/2][31:16] : hits[(i-2)/2][15:0];
	endfunction
	task automatic check_pkt(input logic [7:0] b, input int n);
		logic [15:0] par, w;
		logic [1:0] f;
		int k;
		par = 16'h0000;
		k = 0;
		evt = evt + 16'h0001;
		while (pkt_q.size() < 3 + 2 * n && k < 8 * n + 40) begin
			step();
			k++;
		end
		for (int i = 0; i <= 2 + 2 * n; i++) begin
			w = (i == 2 + 2 * n) ? par : pkt_word(i, evt, b);
			par ^= w;
			check16("pkt_word", w, pkt_q.size() > 0 ? pkt_q.pop_front() : 16'hxxxx);
			f = flg_q.size() > 0 ? flg_q.pop_front() : 2'bxx;
			check16("pkt_flags", {14'h0000, i == 0, i == 2 + 2 * n}, {14'h0000, f});
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		#500000;
		mismatches++;
		final_report();
	end
	initial begin
		repeat (12) @(posedge clk_i);
		#1 reset_n_i = 1'b1;
		check16("outputs_after_reset", 16'h0000, {13'h0000, queue_overflow_o, busy_o, pkt_valid_o});
		bco_sync_i = 1'b1;
		step();
		bco_sync_i = 1'b0;
		cnt = 8'h00;
		evt = 16'h0000;
		for (int r = 0; r < 6; r++) begin
			tick();
			nhits = ($random(seed) & 3) + 1;
			put_hits(nhits);
			accept(8'h00);
			check_pkt(cnt, nhits);
			accept(8'h40);
			check_pkt(cnt - 8'h40, 0);
		end
		tick();
		put_hits(tbs_pkg::DEPTH + 1);
		accept(8'h00);
		check_pkt(cnt, tbs_pkg::DEPTH);
		tick();
		put_hits(2);
		// Ten accepts on consecutive cycles: one runs, eight wait, the last is dropped.
		for (int i = 0; i < 10; i++) begin
			read_delay_i = (i % 2 == 1) ? 8'h40 : 8'h00;
			first_level_accept_i = 1'b1;
			step();
		end
		first_level_accept_i = 1'b0;
		check16("busy", 16'h0001, {15'h0000, busy_o});
		for (int i = 0; i < 9; i++) begin
			check_pkt((i % 2 == 1) ? cnt - 8'h40 : cnt, (i % 2 == 1) ? 0 : 2);
		end
		check16("queue_overflow", 16'h0001, {15'h0000, queue_overflow_o});
		put_hits(3);
		repeat (64) tick();
		accept(8'h00);
		check_pkt(cnt, 0);
		// Fresh hits after the wrap must start at slot zero, not behind stale ones.
		put_hits(2);
		accept(8'h00);
		check_pkt(cnt, 2);
		// A wrap arriving mid-read ends the packet after the entries already sent.
		tick();
		put_hits(4);
		repeat (63) tick();
		accept(8'h3f);
		repeat (9) step();
		tick();
		check_pkt(cnt - 8'h40, 2);
		repeat (20) step();
		check16("busy_idle", 16'h0000, {15'h0000, busy_o});
		check16("extra_words", 16'h0000, 16'(pkt_q.size()));
		final_report();
	end
endmodule
